// ### logic/rxv_pkg.sv
package rxv_pkg;
  localparam int SESS_MAX = 32;
  localparam int ADDR_W = 16;
  localparam int OFF_W = 11;
  localparam int SESS_W = 5;
  localparam int SESS_LSB = 11;
  localparam int BEAT_BYTES_W = 3;
  localparam int MAC_ADDR_W = 8;

  // window offsets inside one 2 KB session window
  localparam logic [OFF_W-1:0] OFF_CMD = 11'h0600;
  localparam logic [OFF_W-1:0] OFF_STS = 11'h0700;
  localparam logic [OFF_W-1:0] OFF_ERR = 11'h0708;
  localparam logic [OFF_W-1:0] OFF_CNT_L = 11'h0720;
  localparam logic [OFF_W-1:0] OFF_CNT_H = 11'h0724;
  localparam logic [OFF_W-1:0] OFF_FAIL_L = 11'h0728;
  localparam logic [OFF_W-1:0] OFF_FAIL_H = 11'h072C;
  localparam logic [OFF_W-1:0] OFF_EXP = 11'h0730;
  localparam logic [OFF_W-1:0] OFF_RCV = 11'h0734;
  localparam logic [OFF_W-1:0] OFF_MAC_LO = 11'h0000;
  localparam logic [OFF_W-1:0] OFF_MAC_HI = 11'h00FF;

  // command and status field positions
  localparam int CMD_EN_BIT = 0;
  localparam int CMD_CLR_BIT = 1;
  localparam int STS_FAIL_BIT = 0;

  // reset values
  localparam logic [47:0] CNT_RST = 48'h0000_0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0] ERR_RST = 8'h00;
endpackage

// ### logic/rxv_payload_checker.sv
module rxv_payload_checker
  import rxv_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic cmdWr,
  input wire logic cmdEn,
  input wire logic cmdClr,
  input wire logic errRdClr,
  input wire logic beatValid,
  input wire logic [BEAT_BYTES_W-1:0] beatBytes,
  input wire logic [31:0] beatData,
  input wire logic [7:0] errCode,
  output logic checkEn,
  output logic [47:0] byteCount,
  output logic failSeen,
  output logic [47:0] failPos,
  output logic [31:0] expWord,
  output logic [31:0] rcvWord,
  output logic [7:0] errLatch
);
  logic checkEn_q;
  logic [47:0] byteCount_q;
  logic [47:0] byteCount_d;
  logic failSeen_q;
  logic [47:0] failPos_q;
  logic [31:0] expWord_q;
  logic [31:0] rcvWord_q;
  logic [7:0] errLatch_q;
  wire clrNow = cmdWr & cmdClr;
  wire [47:0] countBase = clrNow ? CNT_RST : byteCount_q;
  // expected stream is the running byte position
  wire mismatch = checkEn_q & beatValid & (beatData != byteCount_q[31:0]);
  wire firstFail = mismatch & (~failSeen_q | clrNow);
  wire errCatch = (errCode != ERR_RST) & ((errLatch_q == ERR_RST) | errRdClr);

  assign byteCount_d = countBase + (beatValid ? {45'h0000_0000_0000, beatBytes} : CNT_RST);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      checkEn_q <= 1'b0;
      byteCount_q <= CNT_RST;
    end else begin
      if (cmdWr) begin
        checkEn_q <= cmdEn;
      end
      byteCount_q <= byteCount_d;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      failSeen_q <= 1'b0;
      failPos_q <= CNT_RST;
      expWord_q <= WORD_RST;
      rcvWord_q <= WORD_RST;
    end else if (firstFail) begin
      failSeen_q <= 1'b1;
      failPos_q <= countBase;
      expWord_q <= byteCount_q[31:0];
      rcvWord_q <= beatData;
    end else if (clrNow) begin
      failSeen_q <= 1'b0;
      failPos_q <= CNT_RST;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      errLatch_q <= ERR_RST;
    end else if (errCatch) begin
      errLatch_q <= errCode;
    end else if (errRdClr) begin
      errLatch_q <= ERR_RST;
    end
  end

  assign checkEn = checkEn_q;
  assign byteCount = byteCount_q;
  assign failSeen = failSeen_q;
  assign failPos = failPos_q;
  assign expWord = expWord_q;
  assign rcvWord = rcvWord_q;
  assign errLatch = errLatch_q;
endmodule

// ### logic/rxv_status_regs.sv
module rxv_status_regs
  import rxv_pkg::*;
#(
  parameter int NSESS = SESS_MAX
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  output logic regRdValid,
  output logic [MAC_ADDR_W-1:0] macAddr,
  output logic macWrEn,
  output logic macRdEn,
  output logic [31:0] macWrData,
  input wire logic [31:0] macRdData,
  input wire logic [NSESS-1:0] rxValid,
  input wire logic [NSESS-1:0][BEAT_BYTES_W-1:0] rxBytes,
  input wire logic [NSESS-1:0][31:0] rxData,
  input wire logic [NSESS-1:0][7:0] engineRxErrorCode
);
  logic [1:0] rstSync_q;
  logic rstN;
  logic wr_q;
  logic rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] regRdData_q;
  logic regRdValid_q;
  logic [MAC_ADDR_W-1:0] macAddr_q;
  logic macWrEn_q;
  logic macRdEn_q;
  logic [31:0] macWrData_q;

  logic [NSESS-1:0] cmdWr;
  logic [NSESS-1:0] errRdClr;
  logic [NSESS-1:0] chkEn;
  logic [NSESS-1:0] failSeen;
  logic [NSESS-1:0][47:0] cnt;
  logic [NSESS-1:0][47:0] failPos;
  logic [NSESS-1:0][31:0] expW;
  logic [NSESS-1:0][31:0] rcvW;
  logic [NSESS-1:0][7:0] errLat;

  function automatic logic inMac(input logic [OFF_W-1:0] off);
    return (off >= OFF_MAC_LO) && (off <= OFF_MAC_HI);
  endfunction

  function automatic logic [SESS_W-1:0] sessOf(input logic [ADDR_W-1:0] a);
    return a[SESS_LSB+SESS_W-1:SESS_LSB];
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // request stage: every read made without a write answers two edges after it is taken
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= WORD_RST;
    end else begin
      wr_q <= regWrEn;
      rd_q <= regRdEn & ~regWrEn;
      addr_q <= regAddr;
      wdata_q <= regWrData;
    end
  end

  // MAC sub-area goes to one shared port whatever the session
  wire macHit = inMac(regAddr[OFF_W-1:0]);
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      macAddr_q <= 8'h00;
      macWrEn_q <= 1'b0;
      macRdEn_q <= 1'b0;
      macWrData_q <= WORD_RST;
    end else begin
      macAddr_q <= regAddr[MAC_ADDR_W-1:0];
      macWrEn_q <= regWrEn & macHit;
      macRdEn_q <= regRdEn & ~regWrEn & macHit;
      macWrData_q <= regWrData;
    end
  end

  wire [SESS_W-1:0] selSess = sessOf(addr_q);
  wire [OFF_W-1:0] selOff = addr_q[OFF_W-1:0];
  wire selValid = 32'(selSess) < NSESS;

  genvar gi;
  generate
    for (gi = 0; gi < NSESS; gi++) begin : g_sess
      assign cmdWr[gi] = wr_q && (selSess == SESS_W'(gi)) && (selOff == OFF_CMD);
      assign errRdClr[gi] = rd_q && (selSess == SESS_W'(gi)) && (selOff == OFF_ERR);
      rxv_payload_checker u_chk (
        .clk(mclk),
        .rstN(rstN),
        .cmdWr(cmdWr[gi]),
        .cmdEn(wdata_q[CMD_EN_BIT]),
        .cmdClr(wdata_q[CMD_CLR_BIT]),
        .errRdClr(errRdClr[gi]),
        .beatValid(rxValid[gi]),
        .beatBytes(rxBytes[gi]),
        .beatData(rxData[gi]),
        .errCode(engineRxErrorCode[gi]),
        .checkEn(chkEn[gi]),
        .byteCount(cnt[gi]),
        .failSeen(failSeen[gi]),
        .failPos(failPos[gi]),
        .expWord(expW[gi]),
        .rcvWord(rcvW[gi]),
        .errLatch(errLat[gi])
      );
    end
  endgenerate

  // read selection; unmapped offsets read zero, absent sessions read zero outside the MAC sub-area
  wire [47:0] sCnt = selValid ? cnt[selSess] : CNT_RST;
  wire [47:0] sPos = selValid ? failPos[selSess] : CNT_RST;
  wire [31:0] sExp = selValid ? expW[selSess] : WORD_RST;
  wire [31:0] sRcv = selValid ? rcvW[selSess] : WORD_RST;
  wire [7:0] sErr = selValid ? errLat[selSess] : ERR_RST;
  wire sFail = selValid & failSeen[selSess];
  wire [31:0] rdMux =
    inMac(selOff) ? macRdData :
    (selOff == OFF_STS) ? {31'h0000_0000, sFail} :
    (selOff == OFF_ERR) ? {24'h00_0000, sErr} :
    (selOff == OFF_CNT_L) ? sCnt[31:0] :
    (selOff == OFF_CNT_H) ? {16'h0000, sCnt[47:32]} :
    (selOff == OFF_FAIL_L) ? sPos[31:0] :
    (selOff == OFF_FAIL_H) ? {16'h0000, sPos[47:32]} :
    (selOff == OFF_EXP) ? sExp :
    (selOff == OFF_RCV) ? sRcv :
    WORD_RST;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      regRdData_q <= WORD_RST;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= rd_q;
      if (rd_q) begin
        regRdData_q <= rdMux;
      end
    end
  end

  assign regRdData = regRdData_q;
  assign regRdValid = regRdValid_q;
  assign macAddr = macAddr_q;
  assign macWrEn = macWrEn_q;
  assign macRdEn = macRdEn_q;
  assign macWrData = macWrData_q;

  // checks, per-session ones watched on session zero where one session stands for all; command routing checked for every session
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstN);

  wire ff0 = chkEn[0] & rxValid[0] & (rxData[0] != cnt[0][31:0]) & ~failSeen[0];

  sequence s_clrWrite;
    regWrEn && (regAddr == {5'h00, OFF_CMD}) && regWrData[CMD_CLR_BIT];
  endsequence

  sequence s_quietBeat;
    !rxValid[0] && !cmdWr[0];
  endsequence

  sequence s_errRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_ERR});
  endsequence

  property p_errHold;
    (errLat[0] != 8'h00) && !errRdClr[0] |=> errLat[0] == $past(errLat[0]);
  endproperty
  a_errHold: assert property (p_errHold) else $error("error latch changed while held");

  property p_errReadClr;
    s_errRead ##1 (engineRxErrorCode[0] == 8'h00) |=> errLat[0] == 8'h00;
  endproperty
  a_errReadClr: assert property (p_errReadClr) else $error("error latch not cleared by read");

  property p_errReadOld;
    s_errRead ##1 (errLat[0] != 8'h00) |=> regRdValid && regRdData[7:0] == $past(errLat[0]);
  endproperty
  a_errReadOld: assert property (p_errReadOld) else $error("error read lost the latched code");

  property p_errCap;
    (errLat[0] == 8'h00) && (engineRxErrorCode[0] != 8'h00) |=> errLat[0] == $past(engineRxErrorCode[0]);
  endproperty
  a_errCap: assert property (p_errCap) else $error("error code not captured");

  property p_cntInc;
    !cmdWr[0] |=> cnt[0] == $past(cnt[0]) + ($past(rxValid[0]) ? 48'($past(rxBytes[0])) : 48'h0000_0000_0000);
  endproperty
  a_cntInc: assert property (p_cntInc) else $error("byte count step wrong");

  property p_cntClr;
    s_clrWrite ##1 !rxValid[0] |=> cnt[0] == 48'h0000_0000_0000;
  endproperty
  a_cntClr: assert property (p_cntClr) else $error("byte count not cleared");

  property p_failHold;
    failSeen[0] && !cmdWr[0] |=> $stable(failPos[0]) && $stable(expW[0]) && $stable(rcvW[0]);
  endproperty
  a_failHold: assert property (p_failHold) else $error("fail capture overwritten");

  property p_failPos;
    ff0 && !cmdWr[0] |=> failSeen[0] && failPos[0] == $past(cnt[0]);
  endproperty
  a_failPos: assert property (p_failPos) else $error("fail position wrong");

  property p_failClr;
    s_clrWrite ##1 !rxValid[0] |=> failPos[0] == 48'h0000_0000_0000 && !failSeen[0];
  endproperty
  a_failClr: assert property (p_failClr) else $error("fail position not cleared");

  property p_expCap;
    ff0 |=> expW[0] == $past(cnt[0][31:0]);
  endproperty
  a_expCap: assert property (p_expCap) else $error("expected word not stored");

  property p_rcvCap;
    ff0 |=> rcvW[0] == $past(rxData[0]);
  endproperty
  a_rcvCap: assert property (p_rcvCap) else $error("received word not stored");

  property p_route;
    regWrEn && (regAddr[OFF_W-1:0] == OFF_CMD) && (32'(regAddr[15:11]) < NSESS) |=>
      $onehot(cmdWr) && cmdWr[addr_q[15:11]] && (addr_q[15:11] == $past(regAddr[15:11]));
  endproperty
  a_route: assert property (p_route) else $error("command write routed to wrong session");

  property p_routeHigh;
    regWrEn && (regAddr[15] == 1'b1) && (regAddr[OFF_W-1:0] == OFF_CMD) |=> selSess >= 5'h10;
  endproperty
  a_routeHigh: assert property (p_routeHigh) else $error("upper region decode wrong");

  property p_macShared;
    regRdEn && !regWrEn && inMac(regAddr[OFF_W-1:0]) |=> macRdEn && macAddr == $past(regAddr[7:0]);
  endproperty
  a_macShared: assert property (p_macShared) else $error("MAC access not shared");

  property p_readLat;
    regRdEn && !regWrEn |-> ##2 regRdValid;
  endproperty
  a_readLat: assert property (p_readLat) else $error("read answer not two cycles later");

  property p_enable;
    regWrEn && (regAddr == {5'h00, OFF_CMD}) |-> ##2 chkEn[0] == $past(regWrData[CMD_EN_BIT], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("check enable not written");

  // no beat and no command leaves the count alone
  property p_cntHold;
    s_quietBeat |=> $stable(cnt[0]);
  endproperty
  a_cntHold: assert property (p_cntHold) else $error("byte count moved without a beat");

  property p_cntLowRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_CNT_L}) |-> ##2 regRdData == $past(cnt[0][31:0]);
  endproperty
  a_cntLowRead: assert property (p_cntLowRead) else $error("count low read wrong");

  property p_cntHighRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_CNT_H}) |-> ##2 regRdData == {16'h0000, $past(cnt[0][47:32])};
  endproperty
  a_cntHighRead: assert property (p_cntHighRead) else $error("count high read wrong");

  property p_failHighRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_FAIL_H}) |->
      ##2 regRdData == {16'h0000, $past(failPos[0][47:32])};
  endproperty
  a_failHighRead: assert property (p_failHighRead) else $error("fail position high read wrong");

  property p_expRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_EXP}) |-> ##2 regRdData == $past(expW[0]);
  endproperty
  a_expRead: assert property (p_expRead) else $error("expected word read wrong");

  property p_rcvRead;
    regRdEn && !regWrEn && (regAddr == {5'h00, OFF_RCV}) |-> ##2 regRdData == $past(rcvW[0]);
  endproperty
  a_rcvRead: assert property (p_rcvRead) else $error("received word read wrong");

  // a read in the cycle of a write is dropped
  property p_wrWinsRd;
    regRdEn && regWrEn |-> ##2 !regRdValid;
  endproperty
  a_wrWinsRd: assert property (p_wrWinsRd) else $error("read answered during a write");
endmodule

// ### tb/rxv_mac_model.sv
module rxv_mac_model
  import rxv_pkg::*;
(
  input wire logic mclk,
  input wire logic [MAC_ADDR_W-1:0] macAddr,
  input wire logic macWrEn,
  input wire logic macRdEn,
  input wire logic [31:0] macWrData,
  output logic [31:0] macRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] macMem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      macMem[i] = 32'h0000_0000;
    end
  end
  // one store shared by every session window
  always @(posedge mclk) begin
    if (macWrEn) begin
      macMem[macAddr] <= macWrData;
    end
  end
  // outside a read the bus shows the inverted stored word, never the stored word itself
  assign macRdData = macRdEn ? macMem[macAddr] : ~macMem[macAddr];
endmodule

// ### tb/tb_top.sv
module tb_top
  import rxv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic nrst;
  logic [ADDR_W-1:0] regAddr;
  logic regWrEn;
  logic [31:0] regWrData;
  logic regRdEn;
  logic [31:0] regRdData;
  logic regRdValid;
  logic [MAC_ADDR_W-1:0] macAddr;
  logic macWrEn;
  logic macRdEn;
  logic [31:0] macWrData;
  logic [31:0] macRdData;
  logic [SESS_MAX-1:0] rxValid;
  logic [SESS_MAX-1:0][BEAT_BYTES_W-1:0] rxBytes;
  logic [SESS_MAX-1:0][31:0] rxData;
  logic [SESS_MAX-1:0][7:0] engineRxErrorCode;
  int num_errors;
  int checks_done;

  rxv_status_regs #(.NSESS(SESS_MAX)) u_dut (
    .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .macAddr(macAddr), .macWrEn(macWrEn),
    .macRdEn(macRdEn), .macWrData(macWrData), .macRdData(macRdData),
    .rxValid(rxValid), .rxBytes(rxBytes), .rxData(rxData),
    .engineRxErrorCode(engineRxErrorCode)
  );

  rxv_mac_model u_mac (
    .mclk(mclk), .macAddr(macAddr), .macWrEn(macWrEn), .macRdEn(macRdEn),
    .macWrData(macWrData), .macRdData(macRdData)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string msg);
    int n;
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    n = 0;
    while (regRdValid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 4) begin
      num_errors++;
      $display("[FAIL] %0t %s no read answer", $time, msg);
    end
    check(regRdData, exp, msg);
  endtask

  task automatic beat(input int s, input logic [2:0] b, input logic [31:0] d);
    rxValid[s] = 1'b1;
    rxBytes[s] = b;
    rxData[s] = d;
    @(negedge mclk);
    rxValid[s] = 1'b0;
    @(negedge mclk);
  endtask

  task automatic t_count();
    wr(16'h0600, 32'h0000_0001);
    beat(0, 3'h4, 32'h0000_0000);
    beat(0, 3'h3, 32'h0000_0004);
    beat(0, 3'h7, 32'h0000_0007);
    rd(16'h0720, 32'h0000_000E, "count low");
    rd(16'h0724, 32'h0000_0000, "count high");
    rd(16'h0700, 32'h0000_0000, "no fail");
    rd(16'h2020 + 16'h0700, 32'h0000_0000, "session four untouched");
    beat(2, 3'h4, 32'hFFFF_FFFF);
    rd(16'h1700, 32'h0000_0000, "disabled session no fail");
    rd(16'h1720, 32'h0000_0004, "count without checking");
    wr(16'h0600, 32'h0000_0003);
    rd(16'h0720, 32'h0000_0000, "count cleared");
    $display("t_count done");
  endtask

  task automatic t_fail();
    wr(16'h2E00, 32'h0000_0001);
    beat(5, 3'h4, 32'h0000_0000);
    beat(5, 3'h4, 32'hDEAD_BEEF);
    beat(5, 3'h4, 32'h1234_5678);
    rd(16'h2F28, 32'h0000_0004, "fail pos low");
    rd(16'h2F2C, 32'h0000_0000, "fail pos high");
    rd(16'h2F30, 32'h0000_0004, "expected word");
    rd(16'h2F34, 32'hDEAD_BEEF, "received word");
    rd(16'h2F00, 32'h0000_0001, "fail flag");
    rd(16'h2F20, 32'h0000_000C, "count session five");
    wr(16'h2F30, 32'hFFFF_FFFF);
    rd(16'h2F30, 32'h0000_0004, "expected read only");
    wr(16'h2E00, 32'h0000_0003);
    rd(16'h2F28, 32'h0000_0000, "fail pos cleared");
    rd(16'h2E00, 32'h0000_0000, "command reads zero");
    rd(16'h2F40, 32'h0000_0000, "unmapped offset");
    $display("t_fail done");
  endtask

  task automatic t_err();
    engineRxErrorCode[31] = 8'h5A;
    @(negedge mclk);
    engineRxErrorCode[31] = 8'h33;
    @(negedge mclk);
    engineRxErrorCode[31] = 8'h00;
    repeat (2) @(negedge mclk);
    rd(16'hFF08, 32'h0000_005A, "error latch first code");
    rd(16'hFF08, 32'h0000_0000, "error latch read clear");
    rd(16'h0708, 32'h0000_0000, "session zero latch");
    $display("t_err done");
  endtask

  task automatic t_mac();
    wr(16'h8810, 32'hCAFE_F00D);
    rd(16'h0010, 32'hCAFE_F00D, "mac via session zero");
    rd(16'hF810, 32'hCAFE_F00D, "mac via session31");
    $display("t_mac done");
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    test_done();
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    nrst = 1'b0;
    regAddr = '0;
    regWrEn = 1'b0;
    regWrData = '0;
    regRdEn = 1'b0;
    rxValid = '0;
    rxBytes = '0;
    rxData = '0;
    engineRxErrorCode = '0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    t_count();
    t_fail();
    t_err();
    t_mac();
    test_done();
  end
endmodule
